//--- src/fpcs_pkg.sv
package fpcs_pkg;

  // ***********************************************************
  // Geometry and constants
  // ***********************************************************
  localparam int FPCS_AW = 8;
  localparam int FPCS_BLK_LSB = 4;
  localparam int FPCS_NPIN = 8;
  localparam logic [7:0] FPCS_BLANK = 8'hff;
  localparam logic [FPCS_AW-1:0] FPCS_ADDR_MIN = 8'h00;
  localparam logic [FPCS_AW-1:0] FPCS_ADDR_MAX = 8'hff;
  localparam logic [FPCS_BLK_LSB-1:0] FPCS_OFS_LO = 4'h0;
  localparam logic [FPCS_BLK_LSB-1:0] FPCS_OFS_HI = 4'hf;
  localparam logic FPCS_ACK = 1'b1;
  localparam logic FPCS_NAK = 1'b0;
  localparam logic [15:0] FPCS_SUM_RST = 16'h0000;

  // ***********************************************************
  // Commands, prohibitions, answers, states
  // ***********************************************************
  typedef enum logic [2:0] {
    OP_BATCH_ERASE = 3'b000,
    OP_BLOCK_ERASE = 3'b001,
    OP_WRITE = 3'b010,
    OP_CHECKSUM = 3'b011,
    OP_BLANK_CHECK = 3'b100,
    OP_SEC_SET = 3'b101
  } fpcs_op_t;

  typedef struct packed {
    logic no_batch;
    logic no_block;
    logic no_write;
  } fpcs_sec_t;

  localparam fpcs_sec_t FPCS_SEC_FACTORY = 3'h0;
  localparam fpcs_sec_t FPCS_SEC_NONE = 3'h0;

  typedef struct packed {
    logic [2:0] op;
    logic [FPCS_AW-1:0] first;
    logic [FPCS_AW-1:0] last;
    logic [7:0] data;
    fpcs_sec_t sec;
  } fpcs_cmd_t;

  typedef struct packed {
    logic ack;
    logic [15:0] sum;
  } fpcs_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_VERIFY = 2'b10,
    ST_RESP = 2'b11
  } fpcs_state_t;

endpackage : fpcs_pkg

//--- src/fpcs_flash.sv
module fpcs_flash #(
  parameter int AW = fpcs_pkg::FPCS_AW
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_sec_we,
  input wire fpcs_pkg::fpcs_sec_t i_sec_wdata,
  output fpcs_pkg::fpcs_sec_t o_sec
);
  import fpcs_pkg::*;

  // ***********************************************************
  // Nonvolatile store
  // ***********************************************************
  // No reset here on purpose: array and prohibitions survive the
  // programmer's reset, and start in the shipped, blank state.
  logic [7:0] mem [2**AW] = '{default: FPCS_BLANK};
  fpcs_sec_t sec_q = FPCS_SEC_FACTORY;

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sec_we) begin
      sec_q <= i_sec_wdata;
    end
  end

  assign o_rdata = mem[i_addr];
  assign o_sec = sec_q;

endmodule : fpcs_flash

//--- src/fpcs_top.sv
module fpcs_top #(
  parameter int NPIN = fpcs_pkg::FPCS_NPIN,
  parameter logic [NPIN-1:0] PIN_RST_OUT = '0
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_PROG_ATTACH,
  input wire logic I_SELF_PROG,
  input wire logic I_CMD_VALID,
  input wire fpcs_pkg::fpcs_cmd_t I_CMD,
  output logic O_CMD_READY,
  output logic O_RSP_VALID,
  output fpcs_pkg::fpcs_rsp_t O_RSP,
  input wire logic I_RSP_READY,
  output logic O_PROG_MODE,
  output fpcs_pkg::fpcs_sec_t O_SEC_ACTIVE,
  input wire logic [NPIN-1:0] I_USER_PIN_OUT,
  input wire logic [NPIN-1:0] I_USER_PIN_OE,
  output logic [NPIN-1:0] O_PIN_OUT,
  output logic [NPIN-1:0] O_PIN_OE
);
  import fpcs_pkg::*;

  // ***********************************************************
  // Declarations
  // ***********************************************************
  fpcs_state_t state_q;
  fpcs_cmd_t cmd_q;
  fpcs_sec_t act_q;
  fpcs_sec_t nv_sec;
  fpcs_sec_t eff_sec;
  fpcs_sec_t sec_wdata;
  logic att_m_q;
  logic att_s_q;
  logic prog_mode_q;
  logic self_md;
  logic accept;
  logic bad;
  logic ok_q;
  logic [15:0] sum_q;
  logic [FPCS_AW-1:0] addr_q;
  logic [FPCS_AW-1:0] hi_q;
  logic [FPCS_AW-1:0] lo_d;
  logic [FPCS_AW-1:0] hi_d;
  logic at_end;
  logic fl_we;
  logic [7:0] fl_wdata;
  logic [7:0] fl_rdata;
  logic sec_we;
  logic [NPIN-1:0] pin_out_q;
  logic [NPIN-1:0] pin_oe_q;

  // ***********************************************************
  // Decoding helpers
  // ***********************************************************
  function automatic logic refused(input logic [2:0] op,
                                   input fpcs_sec_t s);
    logic r;
    r = 1'b0;
    case (op)
      OP_BATCH_ERASE: r = s.no_batch;
      OP_BLOCK_ERASE: r = s.no_batch | s.no_block | s.no_write;
      OP_WRITE: r = s.no_write;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : refused
  function automatic logic is_erase(input logic [2:0] op);
    return (op == OP_BATCH_ERASE) || (op == OP_BLOCK_ERASE);
  endfunction : is_erase

  // ***********************************************************
  // Attach pin synchroniser and mode
  // ***********************************************************
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      att_m_q <= 1'b0;
      att_s_q <= 1'b0;
    end else begin
      att_m_q <= I_PROG_ATTACH;
      att_s_q <= att_m_q;
    end
  end

  // A live programmer always wins over self programming
  assign self_md = I_SELF_PROG & ~att_s_q;
  assign O_CMD_READY = (state_q == ST_IDLE) && (att_s_q || self_md);
  assign accept = O_CMD_READY && I_CMD_VALID;

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      prog_mode_q <= 1'b0;
    end else if (!att_s_q) begin
      prog_mode_q <= 1'b0;
    end else if (accept) begin
      prog_mode_q <= 1'b1;
    end
  end

  // Prohibitions are sampled once per session entry
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      act_q <= FPCS_SEC_NONE;
    end else if (accept && att_s_q && !prog_mode_q) begin
      act_q <= nv_sec;
    end
  end

  assign O_PROG_MODE = prog_mode_q;
  assign O_SEC_ACTIVE = act_q;

  assign eff_sec = self_md ? FPCS_SEC_NONE :
                   (prog_mode_q ? act_q : nv_sec);

  // ***********************************************************
  // Command decode
  // ***********************************************************
  always_comb begin
    lo_d = I_CMD.first;
    hi_d = I_CMD.last;
    case (I_CMD.op)
      OP_BATCH_ERASE, OP_BLANK_CHECK: begin
        lo_d = FPCS_ADDR_MIN;
        hi_d = FPCS_ADDR_MAX;
      end
      OP_BLOCK_ERASE: begin
        lo_d = {I_CMD.first[FPCS_AW-1:FPCS_BLK_LSB], FPCS_OFS_LO};
        hi_d = {I_CMD.first[FPCS_AW-1:FPCS_BLK_LSB], FPCS_OFS_HI};
      end
      OP_SEC_SET: begin
        lo_d = FPCS_ADDR_MIN;
        hi_d = FPCS_ADDR_MIN;
      end
      default: ;
    endcase
  end

  // Illegal code, reversed range, refusal or self security set
  assign bad = (I_CMD.op > OP_SEC_SET)
            || (I_CMD.first > I_CMD.last && !is_erase(I_CMD.op)
                && I_CMD.op != OP_BLANK_CHECK
                && I_CMD.op != OP_SEC_SET)
            || refused(I_CMD.op, eff_sec)
            || (self_md && I_CMD.op == OP_SEC_SET);

  // ***********************************************************
  // Sequencer
  // ***********************************************************
  assign at_end = (addr_q == hi_q);

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= bad ? ST_RESP : ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (at_end) begin
            state_q <= (cmd_q.op == OP_WRITE) ? ST_VERIFY : ST_RESP;
          end
        end
        ST_VERIFY: begin
          if (at_end) begin
            state_q <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (I_RSP_READY) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      cmd_q <= '0;
      hi_q <= FPCS_ADDR_MIN;
    end else if (accept) begin
      cmd_q <= I_CMD;
      hi_q <= hi_d;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      addr_q <= FPCS_ADDR_MIN;
    end else if (accept) begin
      addr_q <= lo_d;
    end else if (state_q == ST_EXEC && at_end) begin
      addr_q <= cmd_q.first;
    end else if (state_q == ST_EXEC || state_q == ST_VERIFY) begin
      addr_q <= addr_q + 1'b1;
    end
  end

  // ***********************************************************
  // Result: acknowledge flag and checksum
  // ***********************************************************
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      ok_q <= FPCS_NAK;
    end else if (accept) begin
      ok_q <= bad ? FPCS_NAK : FPCS_ACK;
    end else if (state_q == ST_VERIFY && fl_rdata != cmd_q.data) begin
      ok_q <= FPCS_NAK;
    end else if (state_q == ST_EXEC && cmd_q.op == OP_BLANK_CHECK
                 && fl_rdata != FPCS_BLANK) begin
      ok_q <= FPCS_NAK;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      sum_q <= FPCS_SUM_RST;
    end else if (accept) begin
      sum_q <= FPCS_SUM_RST;
    end else if (state_q == ST_EXEC && cmd_q.op == OP_CHECKSUM) begin
      sum_q <= sum_q + {8'h00, fl_rdata};
    end
  end

  assign O_RSP_VALID = (state_q == ST_RESP);
  assign O_RSP = '{ack: ok_q, sum: sum_q};

  // ***********************************************************
  // Flash and prohibition updates
  // ***********************************************************
  // Programming can only clear bits, so without an erase the
  // verify pass fails for any byte that would need a bit set.
  assign fl_we = (state_q == ST_EXEC)
              && (is_erase(cmd_q.op) || cmd_q.op == OP_WRITE);
  assign fl_wdata = is_erase(cmd_q.op) ? FPCS_BLANK
                  : (fl_rdata & cmd_q.data);

  assign sec_we = (state_q == ST_EXEC) && at_end
               && (cmd_q.op == OP_SEC_SET || cmd_q.op == OP_BATCH_ERASE);

  always_comb begin
    if (cmd_q.op == OP_SEC_SET) begin
      sec_wdata = nv_sec | cmd_q.sec;
    end else if (nv_sec.no_batch) begin
      sec_wdata = nv_sec;
    end else begin
      sec_wdata = FPCS_SEC_NONE;
    end
  end

  fpcs_flash #(
    .AW(FPCS_AW)
  ) u_flash (
    .i_clk(I_REF_CLK),
    .i_we(fl_we),
    .i_addr(addr_q),
    .i_wdata(fl_wdata),
    .o_rdata(fl_rdata),
    .i_sec_we(sec_we),
    .i_sec_wdata(sec_wdata),
    .o_sec(nv_sec)
  );

  // ***********************************************************
  // Pin state
  // ***********************************************************
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      pin_out_q <= PIN_RST_OUT;
      pin_oe_q <= '0;
    end else if (prog_mode_q) begin
      pin_out_q <= PIN_RST_OUT;
      pin_oe_q <= '0;
    end else if (!self_md) begin
      pin_out_q <= I_USER_PIN_OUT;
      pin_oe_q <= I_USER_PIN_OE;
    end
  end

  assign O_PIN_OUT = pin_out_q;
  assign O_PIN_OE = pin_oe_q;

  // ***********************************************************
  // Checks
  // ***********************************************************
  property p_answer_bound;
    @(posedge I_REF_CLK) disable iff (I_RST)
    accept |-> ##[1:600] O_RSP_VALID;
  endproperty
  a_answer_bound: assert property (p_answer_bound)
    else $error("command without response");
  property p_illegal_nak;
    @(posedge I_REF_CLK) disable iff (I_RST)
    accept && I_CMD.op > OP_SEC_SET |=> O_RSP_VALID && !O_RSP.ack;
  endproperty
  a_illegal_nak: assert property (p_illegal_nak)
    else $error("illegal command not answered negative");
  property p_refuse;
    @(posedge I_REF_CLK) disable iff (I_RST)
    accept && refused(I_CMD.op, eff_sec)
      |=> O_RSP_VALID && !O_RSP.ack && !fl_we;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("refused command touched flash or acked");
  property p_sticky;
    @(posedge I_REF_CLK) disable iff (I_RST)
    nv_sec.no_batch |=> (nv_sec & $past(nv_sec)) == $past(nv_sec);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("prohibition cleared under batch prohibition");
  property p_session_stable;
    @(posedge I_REF_CLK) disable iff (I_RST)
    prog_mode_q && att_s_q |=> $stable(act_q);
  endproperty
  a_session_stable: assert property (p_session_stable)
    else $error("active security changed inside session");
  property p_pins_reset;
    @(posedge I_REF_CLK) disable iff (I_RST)
    prog_mode_q |=> O_PIN_OE == '0 && O_PIN_OUT == PIN_RST_OUT;
  endproperty
  a_pins_reset: assert property (p_pins_reset)
    else $error("pins left reset state in programming mode");
  property p_self_hold;
    @(posedge I_REF_CLK) disable iff (I_RST)
    self_md && !prog_mode_q |=> $stable(O_PIN_OUT) && $stable(O_PIN_OE);
  endproperty
  a_self_hold: assert property (p_self_hold)
    else $error("pins moved during self programming");
  property p_self_no_sec;
    @(posedge I_REF_CLK) disable iff (I_RST)
    accept && self_md && I_CMD.op == OP_SEC_SET
      |=> !O_RSP.ack ##0 $stable(nv_sec);
  endproperty
  a_self_no_sec: assert property (p_self_no_sec)
    else $error("security set taken in self programming");
  property p_entry;
    @(posedge I_REF_CLK) disable iff (I_RST)
    accept && att_s_q |=> prog_mode_q || !att_s_q;
  endproperty
  a_entry: assert property (p_entry)
    else $error("programming mode not entered");
endmodule : fpcs_top

//--- sim/fpcs_prog_model.sv
module fpcs_prog_model
  import fpcs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_cmd_ready,
  input wire logic i_rsp_valid,
  input wire logic [3:0] i_stall,
  output logic o_cmd_valid,
  output fpcs_pkg::fpcs_cmd_t o_cmd,
  output logic o_rsp_ready
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = '0;
    o_rsp_ready = 1'b0;
  end

  // ***********************************************************
  // One command, one response; bounded waits on both halves
  // ***********************************************************
  task automatic send(input fpcs_cmd_t c);
    logic got;
    int n;
    got = 1'b0;
    n = 0;
    @(posedge i_clk);
    #1;
    o_cmd_valid = 1'b1;
    o_cmd = c;
    while (!got && n < 2000) begin
      @(negedge i_clk);
      got = i_cmd_ready;
      @(posedge i_clk);
      #1;
      n++;
    end
    // Idle lines carry garbage so a stale command is never trusted
    o_cmd_valid = 1'b0;
    o_cmd = ~c;
    got = 1'b0;
    while (!got && n < 4000) begin
      @(negedge i_clk);
      got = i_rsp_valid;
      n++;
    end
    repeat (i_stall) @(posedge i_clk);
    @(posedge i_clk);
    #1;
    o_rsp_ready = 1'b1;
    @(posedge i_clk);
    #1;
    o_rsp_ready = 1'b0;
  endtask : send
endmodule : fpcs_prog_model

//--- sim/tb_flash_programming_command_security.sv
`define FPCS_CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
  end

module tb_flash_programming_command_security;
  import fpcs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0] PIN_RST = 8'ha5;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic attach = 1'b0;
  logic self_md = 1'b0;
  logic cmd_valid, cmd_ready, rsp_valid, rsp_ready, prog_mode;
  fpcs_cmd_t cmd_bus;
  fpcs_rsp_t rsp;
  fpcs_sec_t sec_act;
  logic [7:0] upin = 8'h00;
  logic [7:0] uoe = 8'h00;
  logic [7:0] pin, pin_oe;
  logic [3:0] stall = 4'h0;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  fpcs_rsp_t exp_q[$];
  fpcs_rsp_t exp_rsp;
  logic [7:0] mem [256];
  fpcs_sec_t sto = FPCS_SEC_FACTORY;
  fpcs_sec_t act = FPCS_SEC_NONE;
  logic fresh = 1'b0;

  always #2.5 clk = ~clk;

  fpcs_top #(.PIN_RST_OUT(PIN_RST)) u_dut (
    .I_REF_CLK(clk), .I_RST(rst), .I_PROG_ATTACH(attach),
    .I_SELF_PROG(self_md), .I_CMD_VALID(cmd_valid), .I_CMD(cmd_bus),
    .O_CMD_READY(cmd_ready), .O_RSP_VALID(rsp_valid), .O_RSP(rsp),
    .I_RSP_READY(rsp_ready), .O_PROG_MODE(prog_mode),
    .O_SEC_ACTIVE(sec_act), .I_USER_PIN_OUT(upin), .I_USER_PIN_OE(uoe),
    .O_PIN_OUT(pin), .O_PIN_OE(pin_oe)
  );

  fpcs_prog_model u_prog (
    .i_clk(clk), .i_cmd_ready(cmd_ready), .i_rsp_valid(rsp_valid),
    .i_stall(stall), .o_cmd_valid(cmd_valid), .o_cmd(cmd_bus),
    .o_rsp_ready(rsp_ready)
  );

  // ***********************************************************
  // Response scoreboard and run limits
  // ***********************************************************
  always @(negedge clk) begin
    if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("MISMATCH t=%0t got=%0h exp=none", $time, rsp);
      end else begin
        // Pop once: the compare macro names its arguments twice
        exp_rsp = exp_q.pop_front();
        `FPCS_CHK(rsp, exp_rsp)
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      final_report();
    end
  end

  // User logic keeps toggling pins the device must not follow
  always @(posedge clk) begin
    #1;
    upin = 8'($urandom);
    uoe = 8'($urandom);
  end

  task automatic final_report();
    $display("TB: checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // ***********************************************************
  // Reference behaviour of one command
  // ***********************************************************
  task automatic cmd(input logic [2:0] op, input logic [7:0] f,
                     input logic [7:0] l, input logic [7:0] d,
                     input fpcs_sec_t s);
    fpcs_cmd_t c;
    fpcs_rsp_t e;
    fpcs_sec_t a;
    logic [7:0] nv;
    if (fresh) begin
      act = sto;
      fresh = 1'b0;
    end
    a = self_md ? FPCS_SEC_NONE : act;
    e = '0;
    e.ack = FPCS_ACK;
    case (op)
      OP_BATCH_ERASE: begin
        if (a.no_batch) begin
          e.ack = FPCS_NAK;
        end else begin
          for (int i = 0; i < 256; i++) mem[i] = FPCS_BLANK;
          if (!sto.no_batch) begin
            sto.no_block = 1'b0;
            sto.no_write = 1'b0;
          end
        end
      end
      OP_BLOCK_ERASE: begin
        if (a != FPCS_SEC_NONE) begin
          e.ack = FPCS_NAK;
        end else begin
          for (int i = 0; i < 16; i++) mem[{f[7:4], 4'h0} + i] = FPCS_BLANK;
        end
      end
      OP_WRITE: begin
        if (f > l || a.no_write) begin
          e.ack = FPCS_NAK;
        end else begin
          for (int i = f; i <= l; i++) begin
            nv = mem[i] & d;
            if (nv != d) e.ack = FPCS_NAK;
            mem[i] = nv;
          end
        end
      end
      OP_CHECKSUM: begin
        if (f > l) e.ack = FPCS_NAK;
        else for (int i = f; i <= l; i++) e.sum += 16'(mem[i]);
      end
      OP_BLANK_CHECK: begin
        for (int i = 0; i < 256; i++) begin
          if (mem[i] != FPCS_BLANK) e.ack = FPCS_NAK;
        end
      end
      OP_SEC_SET: begin
        if (self_md) e.ack = FPCS_NAK;
        else sto = sto | s;
      end
      default: e.ack = FPCS_NAK;
    endcase
    c = '0;
    c.op = op;
    c.first = f;
    c.last = l;
    c.data = d;
    c.sec = s;
    exp_q.push_back(e);
    u_prog.send(c);
  endtask : cmd

  task automatic session();
    @(posedge clk);
    #1;
    attach = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    attach = 1'b1;
    repeat (4) @(posedge clk);
    fresh = 1'b1;
    cmd(OP_CHECKSUM, 8'h00, 8'hff, 8'h00, 3'h0);
    @(negedge clk);
    `FPCS_CHK(prog_mode, 1'b1)
    `FPCS_CHK(sec_act, act)
    `FPCS_CHK(pin, PIN_RST)
    `FPCS_CHK(pin_oe, 8'h00)
  endtask : session

  // ***********************************************************
  // Main sequence
  // ***********************************************************
  initial begin
    logic [7:0] b;
    logic [7:0] hold;
    void'($urandom(57493));
    for (int i = 0; i < 256; i++) mem[i] = FPCS_BLANK;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    @(negedge clk);
    `FPCS_CHK({cmd_ready, rsp_valid, prog_mode}, 3'h0)
    `FPCS_CHK(sec_act, FPCS_SEC_NONE)
    session();
    cmd(OP_BLANK_CHECK, 8'h00, 8'hff, 8'h00, 3'h0);
    for (int k = 0; k < 5; k++) begin
      b = 8'($urandom_range(0, 200));
      stall = 4'($urandom_range(0, 5));
      cmd(OP_WRITE, b, b + 8'($urandom_range(0, 15)), 8'($urandom),
          3'h0);
    end
    cmd(OP_CHECKSUM, 8'h00, 8'hff, 8'h00, 3'h0);
    cmd(OP_WRITE, 8'h05, 8'h04, 8'h00, 3'h0);
    cmd(OP_CHECKSUM, 8'h09, 8'h08, 8'h00, 3'h0);
    cmd(3'h6, 8'h00, 8'h00, 8'h00, 3'h0);
    cmd(3'h7, 8'h00, 8'h00, 8'h00, 3'h0);
    cmd(OP_WRITE, 8'h30, 8'h4f, 8'h3c, 3'h0);
    cmd(OP_BLOCK_ERASE, 8'h37, 8'h00, 8'h00, 3'h0);
    cmd(OP_CHECKSUM, 8'h20, 8'h5f, 8'h00, 3'h0);
    cmd(OP_BATCH_ERASE, 8'h00, 8'h00, 8'h00, 3'h0);
    cmd(OP_BLANK_CHECK, 8'h00, 8'hff, 8'h00, 3'h0);
    cmd(OP_WRITE, 8'h20, 8'h2f, 8'($urandom), 3'h0);
    cmd(OP_SEC_SET, 8'h00, 8'h00, 8'h00, 3'b011);
    cmd(OP_BLOCK_ERASE, 8'h20, 8'h00, 8'h00, 3'h0);
    session();
    cmd(OP_BLOCK_ERASE, 8'h20, 8'h00, 8'h00, 3'h0);
    cmd(OP_WRITE, 8'h00, 8'h0f, 8'h11, 3'h0);
    cmd(OP_CHECKSUM, 8'h00, 8'hff, 8'h00, 3'h0);
    cmd(OP_BATCH_ERASE, 8'h00, 8'h00, 8'h00, 3'h0);
    session();
    cmd(OP_WRITE, 8'h40, 8'h47, 8'h5a, 3'h0);
    cmd(OP_SEC_SET, 8'h00, 8'h00, 8'h00, 3'b100);
    session();
    cmd(OP_BATCH_ERASE, 8'h00, 8'h00, 8'h00, 3'h0);
    cmd(OP_BLOCK_ERASE, 8'h40, 8'h00, 8'h00, 3'h0);
    cmd(OP_WRITE, 8'h40, 8'h47, 8'h5a, 3'h0);
    cmd(OP_WRITE, 8'h40, 8'h41, 8'hff, 3'h0);
    cmd(OP_CHECKSUM, 8'h40, 8'h47, 8'h00, 3'h0);
    session();
    // Reset mid-run: outputs clear, stored prohibitions survive
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    @(negedge clk);
    `FPCS_CHK({cmd_ready, rsp_valid, prog_mode}, 3'h0)
    `FPCS_CHK(sec_act, FPCS_SEC_NONE)
    `FPCS_CHK(pin, PIN_RST)
    `FPCS_CHK(pin_oe, 8'h00)
    session();
    // Self programming: prohibitions ignored, pins frozen
    @(posedge clk);
    #1;
    attach = 1'b0;
    self_md = 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    hold = pin;
    cmd(OP_BLOCK_ERASE, 8'h40, 8'h00, 8'h00, 3'h0);
    cmd(OP_SEC_SET, 8'h00, 8'h00, 8'h00, 3'b010);
    cmd(OP_BLANK_CHECK, 8'h00, 8'hff, 8'h00, 3'h0);
    @(negedge clk);
    `FPCS_CHK(pin, hold)
    repeat (20) @(posedge clk);
    `FPCS_CHK(exp_q.size(), 0)
    final_report();
  end
endmodule : tb_flash_programming_command_security
